// File: shared/csc_map.vh
/*
 Register map, reset values and timing constants of the commutation
 search check block. Assumes a 32-bit AXI4-Lite bus and a 100 MHz clock.
*/
`ifndef CSC_MAP_VH
`define CSC_MAP_VH

`define CSC_OFS_CMD        8'h00
`define CSC_OFS_CHECK_SEL  8'h04
`define CSC_OFS_PERSIST    8'h08
`define CSC_OFS_SPEED_THR  8'h0C
`define CSC_OFS_STATUS     8'h10
`define CSC_OFS_IRQ_STAT   8'h14
`define CSC_OFS_IRQ_MASK   8'h18

`define CSC_CMD_ARM_BIT    0
`define CSC_CMD_CANCEL_BIT 1

`define CSC_RST_CHECK_SEL  2'h1
`define CSC_RST_PERSIST    16'h0064
`define CSC_RST_SPEED_THR  32'h00000000
`define CSC_RST_IRQ_MASK   3'h0

`define CSC_IRQ_DONE_BIT   0
`define CSC_IRQ_ACT_BIT    1
`define CSC_IRQ_PAS_BIT    2

`define CSC_PERSIST_MAX    16'h2710
`define CSC_PASSIVE_REVS   4'hA

`define CSC_CLK_PERIOD_NS  10
`define CSC_MS_NS          1000000
`define CSC_MS_CYCLES      (`CSC_MS_NS / `CSC_CLK_PERIOD_NS)

`endif

// File: verification/csc_checker.sv
/*
 Checker for the commutation search check block: timing relations on
 its ports. Assumes it is bound to csc_top and shares its clock and reset.
*/
module csc_checker #(
   parameter MS_CYCLES = 10
) (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   input wire logic       move_done,
   input wire logic       move_dir_ok,
   input wire logic       search_start,
   input wire logic       torque_move,
   input wire logic       check_fault,
   input wire logic [2:0] search_state_value
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   start_state_a: assert property (search_start |-> ##[0:1] search_state_value == 3'h2)
      else $error("search start without searching state");
   start_pulse_a: assert property (search_start |=> !search_start)
      else $error("search start longer than one cycle");
   move_state_a: assert property (torque_move |-> search_state_value == 3'h3)
      else $error("torque move outside active check");
   move_fault_a: assert property (torque_move && move_done && !move_dir_ok |=> check_fault)
      else $error("wrong move direction not faulted");
   move_end_a: assert property (torque_move && move_done && move_dir_ok |=> !torque_move)
      else $error("torque move stays after good move");
   fault_src_a: assert property ($rose(check_fault) |->
      $past(search_state_value) inside {3'h3, 3'h4})
      else $error("fault raised outside a check");
   state_range_a: assert property (search_state_value <= 3'h4)
      else $error("state value out of range");
   aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped before taken");
   cover property (search_start);
   cover property (torque_move && move_done && !move_dir_ok);
   cover property ($rose(check_fault) && $past(search_state_value) == 3'h4);
endmodule

// File: verification/csc_motor_model.sv
/*
 Behavioural motor and search engine: answers a search start and a torque
 move after a few cycles, spins with revolution pulses. Assumes one clock.
*/
module csc_motor_model (
   input  wire logic        clk,
   input  wire logic        search_start,
   input  wire logic        torque_move,
   input  wire logic        dir_ok,
   input  wire logic        spin,
   input  wire logic        oppose,
   output logic             search_done,
   output logic             move_done,
   output logic             move_dir_ok,
   output logic             rev_pulse,
   output logic [15:0]      torque_cmd,
   output logic [15:0]      accel_meas,
   output logic [31:0]      velocity
);
   logic [1:0] sc, mc;
   logic [2:0] rc;
   logic       tm_d;
   initial begin
      {sc, mc, rc, tm_d, search_done, move_done, move_dir_ok, rev_pulse} = '0;
      {torque_cmd, accel_meas, velocity} = '0;
   end
   always @(posedge clk) begin
      tm_d <= torque_move;
      sc <= search_start ? 2'h3 : (sc != 2'h0 ? sc - 2'h1 : sc);
      search_done <= (sc == 2'h1);
      mc <= (torque_move && !tm_d) ? 2'h3 : (mc != 2'h0 ? mc - 2'h1 : mc);
      move_done <= (mc == 2'h1);
      // direction flag only valid with the done pulse, garbage otherwise
      move_dir_ok <= (mc == 2'h1) ? dir_ok : ~move_dir_ok;
      rc <= spin ? rc + 3'h1 : 3'h0;
      rev_pulse <= spin && rc == 3'h7;
      torque_cmd <= spin ? 16'h0100 : 16'h0000;
      accel_meas <= spin ? (oppose ? 16'hFF80 : 16'h0080) : 16'h0000;
      velocity <= spin ? 32'h000003E8 : 32'h00000000;
   end
endmodule

// File: verification/tb_commutation_search_check.sv
/*
 Testbench for csc_top: register access over AXI4-Lite, arming, cancel,
 all check selections and the interrupt. Assumes csc_motor_model on far side.
*/
`include "csc_map.vh"
module tb_commutation_search_check;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, drive_enable, irq, check_fault;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, velocity;
   logic [1:0] bresp, rresp, wresp;
   logic [2:0] search_state_value;
   logic search_done, move_done, move_dir_ok, rev_pulse, search_start, torque_move;
   logic dir_ok, spin, oppose;
   logic [15:0] torque_cmd, accel_meas;
   int errors, compares, st_cnt, mv_cnt;
   csc_top #(.MS_CYCLES(10)) csc_top_inst (.clk(clk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .drive_enable(drive_enable),
      .search_done(search_done), .move_done(move_done), .move_dir_ok(move_dir_ok),
      .rev_pulse(rev_pulse), .torque_cmd(torque_cmd), .accel_meas(accel_meas),
      .velocity(velocity), .search_start(search_start), .torque_move(torque_move),
      .check_fault(check_fault), .search_state_value(search_state_value), .irq(irq));
   csc_motor_model csc_motor_model_inst (.clk(clk), .search_start(search_start),
      .torque_move(torque_move), .dir_ok(dir_ok), .spin(spin), .oppose(oppose),
      .search_done(search_done), .move_done(move_done), .move_dir_ok(move_dir_ok),
      .rev_pulse(rev_pulse), .torque_cmd(torque_cmd), .accel_meas(accel_meas),
      .velocity(velocity));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (search_start === 1'b1) st_cnt++;
      if (torque_move === 1'b1) mv_cnt++;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task finish_test;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      for (n = 0; n < 50 && bvalid !== 1'b1; n++) begin
         @(posedge clk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end
      if (n == 50) chk(0, 1);
      // bvalid was seen high at this edge, so bresp still holds the answer here
      wresp = bresp;
      bready <= 0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      araddr <= a; arvalid <= 1;
      for (n = 0; n < 50 && rvalid !== 1'b1; n++) begin
         @(posedge clk);
         if (arready) arvalid <= 0;
      end
      if (n == 50) chk(0, 1);
      // late ready keeps the slave holding its answer for a while
      rready <= 1;
      @(posedge clk);
      d = rdata; r = rresp;
      rready <= 0;
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d, exp);
      chk(r, er);
   endtask
   task t_regs;
      rchk(8'h04, 32'h1, 2'h0);
      rchk(8'h08, 32'h64, 2'h0);
      rchk(8'h0C, 32'h0, 2'h0);
      rchk(8'h18, 32'h0, 2'h0);
      wr(8'h04, 32'h3);
      chk(wresp, 2'h0);
      rchk(8'h04, 32'h1, 2'h0);
      wr(8'h08, 32'h2711);
      rchk(8'h08, 32'h64, 2'h0);
      rchk(8'h40, 32'h0, 2'h2);
      wr(8'h40, 32'h5);
      chk(wresp, 2'h2);
      wr(8'h18, 32'h7);
   endtask
   task t_cancel;
      int s;
      wr(8'h00, 32'h1);
      rchk(8'h10, 32'h9, 2'h0);
      wr(8'h00, 32'h2);
      rchk(8'h10, 32'h0, 2'h0);
      s = st_cnt;
      drive_enable <= 1;
      repeat (12) @(posedge clk);
      chk(st_cnt - s, 0);
      drive_enable <= 0;
      repeat (8) @(posedge clk);
   endtask
   task run(input logic [1:0] sel, input logic dok, opp, input logic [2:0] est,
            input int lo, hi);
      int n, lat, m;
      logic [31:0] d;
      logic [1:0] r;
      dir_ok <= dok; oppose <= opp; spin <= 1; m = mv_cnt; lat = 0;
      wr(8'h04, {30'h0, sel});
      wr(8'h00, 32'h1);
      rd(8'h10, d, r);
      chk(d[2:0], 3'h1);
      drive_enable <= 1;
      for (n = 0; n < 400 && irq !== 1'b1; n++) begin
         @(posedge clk);
         if (search_state_value === 3'h4) lat++;
      end
      chk(mv_cnt != m, sel == 2'h1);
      rd(8'h14, d, r);
      chk(d[2:0], est);
      chk(lat >= lo && lat <= hi, 1);
      chk(check_fault, est != 3'h1);
      drive_enable <= 0; spin <= 0;
      wr(8'h18, 32'h0);
      repeat (2) @(posedge clk);
      chk(irq, 0);
      wr(8'h18, 32'h7);
      repeat (2) @(posedge clk);
      chk(irq, 1);
      repeat (8) @(posedge clk);
      wr(8'h14, 32'h7);
      repeat (2) @(posedge clk);
      chk(irq, 0);
      rchk(8'h10, {26'h0, est != 3'h1, 5'h00}, 2'h0);
   endtask
   initial begin
      rst = 1; {awvalid, wvalid, bready, arvalid, rready, drive_enable} = '0;
      {awaddr, araddr, wdata, dir_ok, spin, oppose} = '0;
      {errors, compares, st_cnt, mv_cnt} = '0;
      repeat (8) @(posedge clk);
      rst <= 0;
      t_regs;
      t_cancel;
      run(2'h0, 1, 0, 3'h1, 0, 0);
      run(2'h1, 1, 0, 3'h1, 0, 0);
      run(2'h1, 0, 0, 3'h2, 0, 0);
      wr(8'h08, 32'h2);
      run(2'h2, 1, 1, 3'h4, 20, 24);
      run(2'h2, 1, 0, 3'h1, 70, 82);
      wr(8'h08, 32'h0);
      run(2'h2, 1, 1, 3'h1, 70, 82);
      wr(8'h08, 32'h2);
      wr(8'h0C, 32'h7D0);
      run(2'h2, 1, 1, 3'h1, 70, 82);
      finish_test;
   end
   initial begin
      #300000;
      errors++;
      finish_test;
   end
endmodule
bind csc_top csc_checker #(.MS_CYCLES(MS_CYCLES)) csc_checker_inst (.clk(clk), .rst(rst),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .move_done(move_done), .move_dir_ok(move_dir_ok),
   .search_start(search_start), .torque_move(torque_move), .check_fault(check_fault),
   .search_state_value(search_state_value));

// File: verilog/csc_persist.v
/*
 Persistence timer: raises expired once cond has held without a break
 for persist_ms milliseconds, and never while persist_ms is zero.
 Assumes a one-cycle-per-clock cond input from logic on the same clock.
*/
`include "csc_map.vh"

module csc_persist #(
   parameter MS_CYCLES = `CSC_MS_CYCLES
) (
   input  wire        clk,
   input  wire        rst,
   input  wire        cond,
   input  wire [15:0] persist_ms,
   output reg         expired
);

   reg  [31:0] tick_reg;
   reg  [15:0] ms_reg;
   wire        ms_tick;

   assign ms_tick = (tick_reg == MS_CYCLES - 1);

   always @(posedge clk) begin
      if (rst) begin
         tick_reg <= 32'h00000000;
         ms_reg   <= 16'h0000;
         expired  <= 1'b0;
      end else if (!cond || persist_ms == 16'h0000) begin
         // any break in the condition restarts the wait from zero
         tick_reg <= 32'h00000000;
         ms_reg   <= 16'h0000;
         expired  <= 1'b0;
      end else begin
         tick_reg <= ms_tick ? 32'h00000000 : tick_reg + 32'h00000001;
         if (ms_tick && ms_reg != persist_ms)
            ms_reg <= ms_reg + 16'h0001;
         expired <= (ms_reg == persist_ms);
      end
   end

endmodule

// File: verilog/csc_top.v
/*
 Commutation search check: arming, sequencing and post-search checks,
 with an AXI4-Lite register slave and a level interrupt. Assumes the
 search engine, torque move and feedback run on clk; drive_enable is a pin.
*/
`include "csc_map.vh"

module csc_top #(
   parameter MS_CYCLES = `CSC_MS_CYCLES,
   parameter TW        = 16
) (
   input  wire          clk,
   input  wire          rst,
   input  wire [7:0]    s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output reg           s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output reg           s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [7:0]    s_axi_araddr,
   input  wire          s_axi_arvalid,
   output reg           s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   input  wire          drive_enable,
   input  wire          search_done,
   input  wire          move_done,
   input  wire          move_dir_ok,
   input  wire          rev_pulse,
   input  wire [TW-1:0] torque_cmd,
   input  wire [TW-1:0] accel_meas,
   input  wire [31:0]   velocity,
   output reg           search_start,
   output reg           torque_move,
   output reg           check_fault,
   output reg  [2:0]    search_state_value,
   output reg           irq
);

   localparam ST_IDLE    = 3'd0;
   localparam ST_ARMED   = 3'd1;
   localparam ST_SEARCH  = 3'd2;
   localparam ST_ACTIVE  = 3'd3;
   localparam ST_PASSIVE = 3'd4;

   function [31:0] strb_merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0]  strb;
      integer      i;
      begin
         strb_merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (strb[i])
               strb_merge[i*8 +: 8] = data[i*8 +: 8];
      end
   endfunction

   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `CSC_OFS_CMD) || (a == `CSC_OFS_CHECK_SEL) ||
                  (a == `CSC_OFS_PERSIST) || (a == `CSC_OFS_SPEED_THR) ||
                  (a == `CSC_OFS_STATUS) || (a == `CSC_OFS_IRQ_STAT) ||
                  (a == `CSC_OFS_IRQ_MASK);
      end
   endfunction

   // drive enable pin synchroniser
   reg         en_s1_reg;
   reg         en_s2_reg;
   reg         en_s3_reg;
   reg         en_reg;
   reg         en_prev_reg;
   wire        en_rise;

   always @(posedge clk) begin
      if (rst) begin
         en_s1_reg   <= 1'b0;
         en_s2_reg   <= 1'b0;
         en_s3_reg   <= 1'b0;
         en_reg      <= 1'b0;
         en_prev_reg <= 1'b0;
      end else begin
         en_s1_reg   <= drive_enable;
         en_s2_reg   <= en_s1_reg;
         en_s3_reg   <= en_s2_reg;
         if (en_s2_reg == en_s3_reg)
            en_reg <= en_s3_reg;
         en_prev_reg <= en_reg;
      end
   end

   assign en_rise = en_reg && !en_prev_reg;

   // AXI4-Lite slave
   reg         aw_hold_reg;
   reg         w_hold_reg;
   reg  [7:0]  awaddr_reg;
   reg  [31:0] wdata_reg;
   reg  [3:0]  wstrb_reg;
   wire        wr_fire;

   assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

   always @(posedge clk) begin
      if (rst) begin
         aw_hold_reg   <= 1'b0;
         w_hold_reg    <= 1'b0;
         awaddr_reg    <= 8'h00;
         wdata_reg     <= 32'h00000000;
         wstrb_reg     <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg   <= 1'b1;
            awaddr_reg    <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg   <= 1'b1;
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_reg) ? 2'h0 : 2'h2;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // registers
   reg  [1:0]  check_select;
   reg  [15:0] check_persist_time;
   reg  [31:0] check_speed_threshold;
   reg  [2:0]  irq_stat_reg;
   reg  [2:0]  irq_mask_reg;
   reg  [2:0]  irq_set;
   reg         arm_pend_reg;
   wire        wr_cmd;
   wire        arm_search_command;
   wire        cancel_search_command;
   wire [31:0] sel_new;
   wire [31:0] per_new;
   wire [31:0] stat_clr;

   assign wr_cmd   = wr_fire && (awaddr_reg == `CSC_OFS_CMD) && wstrb_reg[0];
   assign arm_search_command    = wr_cmd && wdata_reg[`CSC_CMD_ARM_BIT];
   assign cancel_search_command = wr_cmd && wdata_reg[`CSC_CMD_CANCEL_BIT];
   assign sel_new  = strb_merge({30'h0, check_select}, wdata_reg, wstrb_reg);
   assign per_new  = strb_merge({16'h0, check_persist_time}, wdata_reg, wstrb_reg);
   assign stat_clr = strb_merge(32'h0, wdata_reg, wstrb_reg);

   always @(posedge clk) begin
      if (rst) begin
         check_select          <= `CSC_RST_CHECK_SEL;
         check_persist_time    <= `CSC_RST_PERSIST;
         check_speed_threshold <= `CSC_RST_SPEED_THR;
         irq_mask_reg          <= `CSC_RST_IRQ_MASK;
         irq_stat_reg          <= 3'h0;
         irq                   <= 1'b0;
      end else begin
         if (wr_fire) begin
            // out-of-range selections are ignored to keep a valid mode
            if (awaddr_reg == `CSC_OFS_CHECK_SEL && sel_new[1:0] != 2'h3)
               check_select <= sel_new[1:0];
            if (awaddr_reg == `CSC_OFS_PERSIST && per_new[15:0] <= `CSC_PERSIST_MAX)
               check_persist_time <= per_new[15:0];
            if (awaddr_reg == `CSC_OFS_SPEED_THR)
               check_speed_threshold <= strb_merge(check_speed_threshold,
                                                   wdata_reg, wstrb_reg);
            if (awaddr_reg == `CSC_OFS_IRQ_MASK)
               irq_mask_reg <= stat_clr[2:0];
         end
         // a new event wins over a clear in the same cycle
         irq_stat_reg <= (irq_stat_reg &
                          ~((wr_fire && awaddr_reg == `CSC_OFS_IRQ_STAT) ?
                            stat_clr[2:0] : 3'h0)) | irq_set;
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
         case (s_axi_araddr)
            `CSC_OFS_CHECK_SEL: s_axi_rdata <= {30'h0, check_select};
            `CSC_OFS_PERSIST:   s_axi_rdata <= {16'h0, check_persist_time};
            `CSC_OFS_SPEED_THR: s_axi_rdata <= check_speed_threshold;
            `CSC_OFS_STATUS:    s_axi_rdata <= {26'h0, check_fault, en_reg,
                                                arm_pend_reg, search_state_value};
            `CSC_OFS_IRQ_STAT:  s_axi_rdata <= {29'h0, irq_stat_reg};
            `CSC_OFS_IRQ_MASK:  s_axi_rdata <= {29'h0, irq_mask_reg};
            default:            s_axi_rdata <= 32'h00000000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // passive monitoring
   wire [31:0] speed_abs;
   wire        speed_ok;
   wire        opposed;
   wire        mon_cond;
   wire        persist_hit;

   assign speed_abs = velocity[31] ? (32'h0 - velocity) : velocity;
   assign speed_ok  = $signed(speed_abs) > $signed(check_speed_threshold);
   // a sustained load disturbance also opposes torque and is reported too
   assign opposed   = (torque_cmd[TW-1] != accel_meas[TW-1]) &&
                      (|torque_cmd) && (|accel_meas);
   assign mon_cond  = (search_state_value == ST_PASSIVE) && speed_ok && opposed;

   csc_persist #(
      .MS_CYCLES (MS_CYCLES)
   ) u_persist (
      .clk        (clk),
      .rst        (rst),
      .cond       (mon_cond),
      .persist_ms (check_persist_time),
      .expired    (persist_hit)
   );

   // sequencer
   reg  [3:0]  rev_cnt_reg;

   always @(posedge clk) begin
      if (rst) begin
         search_state_value <= ST_IDLE;
         arm_pend_reg       <= 1'b0;
         search_start       <= 1'b0;
         torque_move        <= 1'b0;
         check_fault        <= 1'b0;
         rev_cnt_reg        <= 4'h0;
         irq_set            <= 3'h0;
      end else begin
         search_start <= 1'b0;
         irq_set      <= 3'h0;
         if (cancel_search_command) begin
            arm_pend_reg       <= 1'b0;
            torque_move        <= 1'b0;
            search_state_value <= ST_IDLE;
         end else begin
            if (arm_search_command) begin
               arm_pend_reg <= 1'b1;
               check_fault  <= 1'b0;
               if (search_state_value == ST_IDLE && !en_reg)
                  search_state_value <= ST_ARMED;
            end
            case (search_state_value)
               ST_IDLE, ST_ARMED: begin
                  if (en_rise && arm_pend_reg) begin
                     arm_pend_reg       <= 1'b0;
                     search_start       <= 1'b1;
                     search_state_value <= ST_SEARCH;
                  end
               end
               ST_SEARCH: begin
                  if (!en_reg) begin
                     search_state_value <= ST_IDLE;
                  end else if (search_done) begin
                     rev_cnt_reg <= 4'h0;
                     case (check_select)
                        2'h1: begin
                           torque_move        <= 1'b1;
                           search_state_value <= ST_ACTIVE;
                        end
                        2'h2:    search_state_value <= ST_PASSIVE;
                        default: begin
                           irq_set[`CSC_IRQ_DONE_BIT] <= 1'b1;
                           search_state_value <= ST_IDLE;
                        end
                     endcase
                  end
               end
               ST_ACTIVE: begin
                  if (!en_reg) begin
                     torque_move        <= 1'b0;
                     search_state_value <= ST_IDLE;
                  end else if (move_done) begin
                     torque_move <= 1'b0;
                     if (!move_dir_ok) begin
                        check_fault               <= 1'b1;
                        irq_set[`CSC_IRQ_ACT_BIT] <= 1'b1;
                     end else begin
                        irq_set[`CSC_IRQ_DONE_BIT] <= 1'b1;
                     end
                     search_state_value <= ST_IDLE;
                  end
               end
               ST_PASSIVE: begin
                  if (persist_hit) begin
                     check_fault               <= 1'b1;
                     irq_set[`CSC_IRQ_PAS_BIT] <= 1'b1;
                     search_state_value        <= ST_IDLE;
                  end else if (!en_reg) begin
                     search_state_value <= ST_IDLE;
                  end else if (rev_pulse) begin
                     if (rev_cnt_reg == `CSC_PASSIVE_REVS - 4'h1) begin
                        irq_set[`CSC_IRQ_DONE_BIT] <= 1'b1;
                        search_state_value <= ST_IDLE;
                     end
                     rev_cnt_reg <= rev_cnt_reg + 4'h1;
                  end
               end
               default: search_state_value <= ST_IDLE;
            endcase
         end
      end
   end

endmodule
